// file: rtl/iplp_consts.vh
`ifndef IPLP_CONSTS_VH
`define IPLP_CONSTS_VH
`define IPLP_ADDR_POWER_CONTROL_REG     8'h87
`define IPLP_ADDR_PRIO_HI  8'hB7
`define IPLP_ADDR_PRIO_LO  8'hB8
`define IPLP_ADDR_ENABLE   8'hA8
`define IPLP_ADDR_STATUS   8'hC0
`define IPLP_NSRC          5
`define IPLP_PRIO_MASK     8'h1F
`define IPLP_POWER_CONTROL_REG_MASK     8'h0F
`define IPLP_BIT_IDLE      0
`define IPLP_BIT_PDOWN     1
`define IPLP_BIT_EA        7
`define IPLP_RST_HOLD_OSC  24
`define IPLP_OSC_PER_CLK   1
`define IPLP_RST_HOLD_CLKS ((`IPLP_RST_HOLD_OSC + `IPLP_OSC_PER_CLK - 1) / `IPLP_OSC_PER_CLK)
`define IPLP_WAKE_STABLE   8'h10
`endif

// file: rtl/iplp_arbiter.v
`timescale 1ns/1ps
`default_nettype none
`include "iplp_consts.vh"
module iplp_arbiter (
  input  wire [4:0] req,
  input  wire [4:0] prio_hi,
  input  wire [4:0] prio_lo,
  input  wire [3:0] active_lvls,
  output reg        grant_vld,
  output reg  [2:0] grant_idx,
  output reg  [1:0] grant_lvl
);
  integer i;
  reg [1:0] lvl;
  reg [1:0] run_top;
  reg       any_run;
  always @* begin
    grant_vld = 1'b0;
    grant_idx = 3'h0;
    grant_lvl = 2'h0;
    lvl       = 2'h0;
    any_run   = |active_lvls;
    run_top   = active_lvls[3] ? 2'h3 : active_lvls[2] ? 2'h2 :
                active_lvls[1] ? 2'h1 : 2'h0;
    // Descending scan keeps lowest index on ties: fixed polling order
    for (i = `IPLP_NSRC - 1; i >= 0; i = i - 1) begin
      lvl = {prio_hi[i], prio_lo[i]};
      if (req[i] && (!any_run || lvl > run_top) &&
          (!grant_vld || lvl >= grant_lvl)) begin
        grant_vld = 1'b1;
        grant_idx = i[2:0];
        grant_lvl = lvl;
      end
    end
  end
endmodule // iplp_arbiter
`default_nettype wire

// file: rtl/iplp_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "iplp_consts.vh"
module iplp_ctrl (
  input  wire        clk,
  input  wire        reset,
  input  wire        clk_en,
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [7:0]  avs_writedata,
  output reg  [7:0]  avs_readdata,
  output reg         avs_waitrequest,
  input  wire [4:0]  irq_req,
  input  wire        ext_irq_zero_pin_n,
  input  wire        ext_irq_one_pin_n,
  input  wire        return_from_interrupt,
  input  wire        instr_done,
  output reg         cpu_clk_en,
  output reg         osc_run,
  output reg         periph_clk_en,
  output reg         sfr_hold,
  output reg         port_hold,
  output reg         port0_float,
  output reg         addr_latch_strobe,
  output reg         program_store_strobe,
  output reg         irq_vector_req,
  output reg  [2:0]  irq_vector_idx
);
  localparam ST_RUN   = 2'h0;
  localparam ST_IDLE  = 2'h1;
  localparam ST_PDOWN = 2'h2;
  localparam ST_WAKE  = 2'h3;

  reg [4:0] priority_low_bits_q;
  reg [4:0] priority_high_bits_q;
  reg [3:0] power_control_reg_q;
  reg [7:0] enable_q;
  reg [1:0] state_q;
  reg [3:0] active_lvls_q;
  reg [7:0] wake_cnt_q;
  reg [1:0] pin_seen_q;
  reg       pend_idle_q;
  reg       pend_pdown_q;
  reg       ack_q;

  wire       grant_vld;
  wire [2:0] grant_idx;
  wire [1:0] grant_lvl;
  wire       ea       = enable_q[`IPLP_BIT_EA];
  wire [4:0] en_req   = irq_req & enable_q[4:0] & {5{ea}};
  wire       x0_wake  = ea & enable_q[0];
  wire       x1_wake  = ea & enable_q[2];
  // Pins are level inputs, so a low is seen with the core clock parked
  wire       pin_low  = (x0_wake & ~ext_irq_zero_pin_n) |
                        (x1_wake & ~ext_irq_one_pin_n);
  wire [1:0] rel_now  = pin_seen_q & {~ext_irq_one_pin_n ? 1'b0 : 1'b1,
                                       ~ext_irq_zero_pin_n ? 1'b0 : 1'b1};
  wire [1:0] lvl_x0   = {priority_high_bits_q[0], priority_low_bits_q[0]};
  wire [1:0] lvl_x1   = {priority_high_bits_q[2], priority_low_bits_q[2]};
  // With both pins seen the higher level wins; a tie falls to pin zero
  wire       wake_x1  = (&pin_seen_q) ? (lvl_x1 > lvl_x0) : rel_now[1];
  wire [1:0] wake_lvl = wake_x1 ? lvl_x1 : lvl_x0;
  wire       wake_ok  = (wake_cnt_q == `IPLP_WAKE_STABLE);
  wire       bus_req  = avs_read | avs_write;
  wire       wr_acc   = avs_write & ~ack_q;
  wire       rd_acc   = avs_read & ~ack_q;

  iplp_arbiter u_arb (
    .req         (en_req),
    .prio_hi     (priority_high_bits_q),
    .prio_lo     (priority_low_bits_q),
    .active_lvls (active_lvls_q),
    .grant_vld   (grant_vld),
    .grant_idx   (grant_idx),
    .grant_lvl   (grant_lvl)
  );

  // One wait cycle per access; answer on the second edge
  always @(posedge clk) begin
    if (reset) begin
      ack_q           <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 8'h00;
    end else if (clk_en) begin
      ack_q           <= bus_req & ~ack_q;
      avs_waitrequest <= ~(bus_req & ~ack_q);
      if (rd_acc) begin
        case (avs_address)
          `IPLP_ADDR_PRIO_LO: avs_readdata <= {3'h0, priority_low_bits_q};
          `IPLP_ADDR_PRIO_HI: avs_readdata <= {3'h0, priority_high_bits_q};
          `IPLP_ADDR_POWER_CONTROL_REG:    avs_readdata <= {4'h0, power_control_reg_q};
          `IPLP_ADDR_ENABLE:  avs_readdata <= enable_q;
          `IPLP_ADDR_STATUS:  avs_readdata <= {2'h0, active_lvls_q, state_q};
          default:            avs_readdata <= 8'h00;
        endcase
      end
    end
  end

  // Registers and low-power sequencing
  always @(posedge clk) begin
    if (reset) begin
      priority_low_bits_q  <= 5'h00;
      priority_high_bits_q <= 5'h00;
      power_control_reg_q  <= 4'h0;
      enable_q             <= 8'h00;
      state_q              <= ST_RUN;
      active_lvls_q        <= 4'h0;
      wake_cnt_q           <= 8'h00;
      pin_seen_q           <= 2'h0;
      pend_idle_q          <= 1'b0;
      pend_pdown_q         <= 1'b0;
      irq_vector_req       <= 1'b0;
      irq_vector_idx       <= 3'h0;
    end else if (clk_en) begin
      irq_vector_req <= 1'b0;
      if (wr_acc && state_q == ST_RUN) begin
        case (avs_address)
          `IPLP_ADDR_PRIO_LO: priority_low_bits_q  <= avs_writedata[4:0];
          `IPLP_ADDR_PRIO_HI: priority_high_bits_q <= avs_writedata[4:0];
          `IPLP_ADDR_ENABLE:  enable_q <= avs_writedata & 8'h9F;
          `IPLP_ADDR_POWER_CONTROL_REG: begin
            power_control_reg_q <= avs_writedata[3:0];
            pend_idle_q  <= avs_writedata[`IPLP_BIT_IDLE];
            pend_pdown_q <= avs_writedata[`IPLP_BIT_PDOWN];
          end
          default: ;
        endcase
      end
      if (return_from_interrupt && state_q == ST_RUN)
        active_lvls_q <= active_lvls_q &
          ~(active_lvls_q[3] ? 4'h8 : active_lvls_q[2] ? 4'h4 :
            active_lvls_q[1] ? 4'h2 : {3'h0, active_lvls_q[0]});
      case (state_q)
        ST_RUN: begin
          if (instr_done && pend_pdown_q) begin
            state_q      <= ST_PDOWN;
            pend_pdown_q <= 1'b0;
            pend_idle_q  <= 1'b0;
          end else if (instr_done && pend_idle_q) begin
            state_q     <= ST_IDLE;
            pend_idle_q <= 1'b0;
          end else if (grant_vld && !return_from_interrupt) begin
            irq_vector_req <= 1'b1;
            irq_vector_idx <= grant_idx;
            active_lvls_q  <= active_lvls_q | (4'h1 << grant_lvl);
          end
        end
        ST_IDLE: begin
          if (grant_vld) begin
            power_control_reg_q[`IPLP_BIT_IDLE] <= 1'b0;
            state_q        <= ST_RUN;
            irq_vector_req <= 1'b1;
            irq_vector_idx <= grant_idx;
            active_lvls_q  <= active_lvls_q | (4'h1 << grant_lvl);
          end
        end
        ST_PDOWN: begin
          // Registers frozen; only the enabled pins are watched
          if (pin_low) begin
            state_q    <= ST_WAKE;
            wake_cnt_q <= 8'h00;
            pin_seen_q <= {x1_wake & ~ext_irq_one_pin_n,
                           x0_wake & ~ext_irq_zero_pin_n};
          end
        end
        ST_WAKE: begin
          if (wake_cnt_q != `IPLP_WAKE_STABLE)
            wake_cnt_q <= wake_cnt_q + 8'h01;
          pin_seen_q <= pin_seen_q | {x1_wake & ~ext_irq_one_pin_n,
                                      x0_wake & ~ext_irq_zero_pin_n};
          // Exit completes on the first release of a pin that went low, but
          // not before the restarted oscillator has had time to settle
          if (|rel_now && wake_ok) begin
            state_q <= ST_RUN;
            power_control_reg_q[`IPLP_BIT_IDLE]  <= 1'b0;
            power_control_reg_q[`IPLP_BIT_PDOWN] <= 1'b0;
            irq_vector_req <= 1'b1;
            irq_vector_idx <= wake_x1 ? 3'h2 : 3'h0;
            // Level marked active is that of the source actually vectored
            active_lvls_q  <= active_lvls_q | (4'h1 << wake_lvl);
          end
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  // Pin and clock-gate outputs, registered from the current state_q, so they follow it one cycle late
  always @(posedge clk) begin
    if (reset) begin
      cpu_clk_en           <= 1'b1;
      osc_run              <= 1'b1;
      periph_clk_en        <= 1'b1;
      sfr_hold             <= 1'b0;
      port_hold            <= 1'b0;
      port0_float          <= 1'b0;
      addr_latch_strobe    <= 1'b1;
      program_store_strobe <= 1'b1;
    end else if (clk_en) begin
      cpu_clk_en    <= (state_q == ST_RUN);
      osc_run       <= (state_q != ST_PDOWN);
      periph_clk_en <= (state_q == ST_RUN) || (state_q == ST_IDLE);
      sfr_hold      <= (state_q == ST_PDOWN) || (state_q == ST_WAKE);
      port_hold     <= (state_q != ST_RUN);
      port0_float   <= (state_q != ST_RUN);
      case (state_q)
        ST_IDLE: begin
          addr_latch_strobe    <= 1'b1;
          program_store_strobe <= 1'b1;
        end
        ST_PDOWN, ST_WAKE: begin
          addr_latch_strobe    <= 1'b0;
          program_store_strobe <= 1'b0;
        end
        default: begin
          addr_latch_strobe    <= 1'b1;
          program_store_strobe <= 1'b1;
        end
      endcase
    end
  end
endmodule // iplp_ctrl
`default_nettype wire

// file: tb/iplp_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module iplp_ctrl_props (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [7:0] avs_address,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic [7:0] avs_readdata,
  input wire logic       avs_waitrequest,
  input wire logic       ext_irq_zero_pin_n,
  input wire logic       ext_irq_one_pin_n,
  input wire logic       cpu_clk_en,
  input wire logic       osc_run,
  input wire logic       periph_clk_en,
  input wire logic       port0_float,
  input wire logic       addr_latch_strobe,
  input wire logic       program_store_strobe,
  input wire logic       irq_vector_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_ans; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_ans: assert property (p_ans) else $error("bus answer late");
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("answer held too long");
  property p_rsv;
    !avs_waitrequest && avs_read && (avs_address == 8'hB7 || avs_address == 8'hB8)
      |-> avs_readdata[7:5] == 3'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_idl; !cpu_clk_en && periph_clk_en |-> addr_latch_strobe && program_store_strobe;
  endproperty
  a_idl: assert property (p_idl) else $error("strobes low in idle");
  property p_pds; !osc_run |-> !addr_latch_strobe && !program_store_strobe && port0_float;
  endproperty
  a_pds: assert property (p_pds) else $error("pins wrong in power-down");
  property p_pdc; !osc_run |-> !cpu_clk_en && !periph_clk_en; endproperty
  a_pdc: assert property (p_pdc) else $error("clocks run in power-down");
  property p_stay; !osc_run && ext_irq_zero_pin_n && ext_irq_one_pin_n |=> !osc_run; endproperty
  a_stay: assert property (p_stay) else $error("woke without a pin");
  property p_vec; irq_vector_req |=> !irq_vector_req; endproperty
  a_vec: assert property (p_vec) else $error("vector request too long");
endmodule // iplp_ctrl_props
bind iplp_ctrl iplp_ctrl_props i_iplp_ctrl_props (.clk, .reset, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .ext_irq_zero_pin_n, .ext_irq_one_pin_n,
  .cpu_clk_en, .osc_run, .periph_clk_en, .port0_float, .addr_latch_strobe,
  .program_store_strobe, .irq_vector_req);
`default_nettype wire

// file: tb/iplp_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module iplp_cpu_model (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic wr_done,
  input  wire logic vec,
  input  wire logic slow,
  output var logic  instr_done,
  output var logic  ret
);
  logic [3:0] cnt_q;
  // A register write ends one instruction, so mode bits act at the next boundary
  always @(posedge clk) begin
    instr_done <= wr_done && !reset;
    ret <= (cnt_q == 4'h1);
    if (reset)
      cnt_q <= 4'h0;
    else if (vec)
      cnt_q <= slow ? 4'hC : 4'h2;
    else if (cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
  end
endmodule // iplp_cpu_model
`default_nettype wire

// file: tb/iplp_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
`define WAITF(c) for (i = 0; i < 400 && ((c) !== 1'b1); i++) @(posedge clk); \
  if ((c) !== 1'b1) begin n_mismatch++; give_verdict(); end
module iplp_ctrl_tb;
  logic       clk, reset, rd, wr, wreq, slow, instr_done, ret, vreq;
  logic       ccen, osc, pcen, ale, pss, p0f, pin0_n, pin1_n, sh, ph;
  logic [7:0] addr, wdata, rdata, q;
  logic [4:0] req;
  logic [2:0] vidx;
  int         n_mismatch, compares, seed, i, r, hi, lo, lv;
  iplp_ctrl i_iplp_ctrl (.clk, .reset, .clk_en(1'b1), .avs_address(addr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wreq),
    .irq_req(req), .ext_irq_zero_pin_n(pin0_n), .ext_irq_one_pin_n(pin1_n),
    .return_from_interrupt(ret), .instr_done, .cpu_clk_en(ccen), .osc_run(osc),
    .periph_clk_en(pcen), .sfr_hold(sh), .port_hold(ph), .port0_float(p0f),
    .addr_latch_strobe(ale), .program_store_strobe(pss), .irq_vector_req(vreq),
    .irq_vector_idx(vidx));
  iplp_cpu_model i_iplp_cpu_model (.clk, .reset, .wr_done(wr && !wreq), .vec(vreq), .slow,
    .instr_done, .ret);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task give_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    `WAITF(!wreq)
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // Ties go to the lowest source index, the fixed polling order
  function logic [2:0] ex_idx(input logic [4:0] rq, input logic [4:0] h, input logic [4:0] l);
    int k, bl;
    ex_idx = 3'h0;
    bl = -1;
    for (k = 0; k < 5; k++) if (rq[k] && int'({h[k], l[k]}) > bl) begin
      ex_idx = k[2:0];
      bl = int'({h[k], l[k]});
    end
  endfunction
  initial begin
    seed = 32'h3B32E275;
    {rd, wr, slow, addr, wdata, req} = '0;
    {reset, pin0_n, pin1_n} = 3'h7;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    bus(0, 8'hB7, 8'h00); `CHK("prio_hi", 8'h00, q)
    bus(0, 8'hB8, 8'h00); `CHK("prio_lo", 8'h00, q)
    bus(0, 8'h55, 8'h00); `CHK("unmapped", 8'h00, q)
    bus(1, 8'hA8, 8'h9F);
    for (r = 0; r < 6; r++) begin
      hi = $random(seed) & 32'h1F;
      lo = $random(seed) & 32'h1F;
      lv = ($random(seed) & 32'h1F) | 32'h1;
      bus(1, 8'hB7, hi[7:0]);
      bus(1, 8'hB8, lo[7:0]);
      bus(0, 8'hB7, 8'h00); `CHK("prio_hi rd", hi[7:0], q)
      bus(0, 8'hB8, 8'h00); `CHK("prio_lo rd", lo[7:0], q)
      slow <= r[0];
      req <= lv[4:0];
      `WAITF(vreq)
      req <= 5'h00;
      `CHK("vector", ex_idx(lv[4:0], hi[4:0], lo[4:0]), vidx)
      `WAITF(ret)
    end
    $display("test priority done");
    bus(1, 8'h87, 8'h01);
    `WAITF(!ccen)
    @(posedge clk);
    `CHK("idle strobe", 2'h3, {ale, pss})
    `CHK("idle periph", 1'b1, pcen)
    `CHK("idle holds", 2'h1, {sh, ph})
    req <= 5'h02;
    `WAITF(vreq)
    req <= 5'h00;
    `CHK("idle wake", 3'h1, vidx)
    `WAITF(ret)
    bus(0, 8'h87, 8'h00); `CHK("idle bit", 8'h00, q & 8'h03)
    $display("test idle done");
    bus(1, 8'h87, 8'h03);
    `WAITF(!osc)
    repeat (3) @(posedge clk);
    `CHK("pd pins", 3'h1, {ale, pss, p0f})
    `CHK("pd holds", 2'h3, {sh, ph})
    pin0_n <= 1'b0;
    `WAITF(osc)
    // Pin stays low well past the restart so the oscillator settles
    repeat (20) @(posedge clk);
    pin0_n <= 1'b1;
    `WAITF(vreq)
    `CHK("pd wake", 3'h0, vidx)
    `WAITF(ret)
    bus(0, 8'h87, 8'h00); `CHK("pd bits", 8'h00, q & 8'h03)
    bus(0, 8'hB8, 8'h00); `CHK("lo kept", lo[7:0], q)
    `CHK("run holds", 2'h0, {sh, ph})
    bus(1, 8'hB7, 8'h04);
    bus(1, 8'hB8, 8'h00);
    bus(1, 8'hA8, 8'h9E);
    bus(1, 8'h87, 8'h02);
    `WAITF(!osc)
    pin0_n <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("pd masked pin", 1'b0, osc)
    pin1_n <= 1'b0;
    `WAITF(osc)
    repeat (20) @(posedge clk);
    pin1_n <= 1'b1;
    `WAITF(vreq)
    `CHK("pd wake one", 3'h2, vidx)
    pin0_n <= 1'b1;
    `WAITF(ret)
    bus(1, 8'hA8, 8'h9F);
    bus(1, 8'h87, 8'h02);
    `WAITF(!osc)
    pin0_n <= 1'b0;
    pin1_n <= 1'b0;
    `WAITF(osc)
    repeat (20) @(posedge clk);
    pin0_n <= 1'b1;
    `WAITF(vreq)
    `CHK("pd both", 3'h2, vidx)
    pin1_n <= 1'b1;
    `WAITF(ret)
    bus(1, 8'h87, 8'h01);
    `WAITF(!ccen)
    reset <= 1'b1;
    repeat (24) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    `CHK("rst clk", 1'b1, ccen)
    bus(0, 8'h87, 8'h00); `CHK("rst bits", 8'h00, q & 8'h03)
    bus(0, 8'hB8, 8'h00); `CHK("rst lo", 8'h00, q)
    $display("test low power done");
    give_verdict();
  end
endmodule // iplp_ctrl_tb
`default_nettype wire
